/* File: inc/pdrt_pkg.sv */
package pdrt_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_DETECT   = 8'h04;
  localparam logic [7:0] OFF_STATUS   = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;

  // CTRL field positions
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_TQSEL_BIT  = 1;
  localparam int unsigned CTRL_REVC0_BIT  = 2;
  localparam logic [2:0]  CTRL_RESET      = 3'h5;

  // Detection time in whole milliseconds
  localparam int unsigned  DET_W        = 10;
  localparam logic [9:0]   DET_RESET_MS = 10'h0C8;
  localparam logic [9:0]   DET_MIN_MS   = 10'h01E;
  localparam logic [9:0]   DET_MAX_C0   = 10'h0C8;
  localparam logic [9:0]   DET_MAX_C1   = 10'h1F4;

  // Interrupt bit positions
  localparam int unsigned IRQ_W         = 4;
  localparam int unsigned IRQ_CP_ALARM  = 0;
  localparam int unsigned IRQ_BUS_ALARM = 1;
  localparam int unsigned IRQ_RIDE_ON   = 2;
  localparam int unsigned IRQ_RIDE_OK   = 3;
  localparam logic [3:0]  IRQ_MASK_RST  = 4'h0;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned MS_PERIOD_NS  = 1000000;
  localparam int unsigned MS_CYCLES     = MS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned PRESC_W       = 15;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PDRT_NORMAL = 2'b00,
    PDRT_RIDE   = 2'b01,
    PDRT_ALARM  = 2'b10
  } pdrt_state_t;

  typedef struct packed {
    logic ctrl_power_lost;
    logic bus_below_normal;
    logic bus_below_alt;
  } pdrt_mon_t;

  typedef struct packed {
    logic  servo_running;
    logic  accelerating;
  } pdrt_drive_t;

endpackage

/* File: design/pdrt_top.sv */
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Function
// (RULE_01) During ride-through the undervoltage alarm is held off and its level moves to the alternate one at once.
// (RULE_02) The control-power alarm delay is taken from a programmable detection time.
// (RULE_03) The bus undervoltage threshold switches by itself while ride-through is in effect.
// (RULE_04) The brake interlock output stays on for the whole ride-through interval.
// (RULE_05) With torque limit selected, torque is limited while accelerating during a power failure in operation.
// (RULE_06) A bus collapse raises the main-circuit alarm whatever the detection time.
// (RULE_07) The detection time is held to 30-200 ms on the newer revision and 30-500 ms on the older.
// (RULE_08) The detection time resets to 200 ms.
// (RULE_09) A control-power loss longer than the detection time raises the control-power alarm.
// (RULE_10) The ride-through output turns on once a control-power failure is detected.
// (RULE_11) The brake interlock output drops at the moment the undervoltage alarm is raised.
// (RULE_12) A bus drop below the level during a short loss still raises the alarm.
// (RULE_13) A short loss with the bus above the level continues without alarm.
// (RULE_14) Software must not map the dynamic brake interlock to any output assignment.
// (RULE_15) Software enables ride-through by setting the enable bit and programming the time.
// (RULE_16) The timer counts whole milliseconds from loss and clears without alarm on return.
// (RULE_17) Ride-through ends when power returns cleanly; an alarm stays latched until reset.
module pdrt_top #(
  parameter int unsigned MS_CYCLES = pdrt_pkg::MS_CYCLES
) (
  input  wire logic               core_clk_i,
  input  wire logic               reset_i,
  input  wire pdrt_pkg::pdrt_mon_t   mon_i,
  input  wire pdrt_pkg::pdrt_drive_t drive_i,
  input  wire logic [7:0]         addr_i,
  input  wire logic [31:0]        wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output logic [31:0]             rdata_o,
  output logic                    irq_o,
  output logic                    ride_through_active_out_o,
  output logic                    malfunction_out_o,
  output logic                    warning_out_o,
  output logic                    brake_interlock_out_o,
  output logic                    uv_level_alt_o,
  output logic                    torque_limit_o
);

  // ------------------------------------------------------------
  // Monitor synchronisers
  // ------------------------------------------------------------
  pdrt_pkg::pdrt_mon_t mon_meta_q;
  pdrt_pkg::pdrt_mon_t mon_q;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      mon_meta_q <= '0;
      mon_q      <= '0;
    end else begin
      mon_meta_q <= mon_i;
      mon_q      <= mon_meta_q;
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic [2:0]               ctrl_q;
  logic [pdrt_pkg::DET_W-1:0] det_q;
  logic [pdrt_pkg::DET_W-1:0] det_max;
  logic [pdrt_pkg::DET_W-1:0] det_wr;
  logic [pdrt_pkg::IRQ_W-1:0] mask_q;
  logic                     ena;
  logic                     tq_sel;

  assign ena     = ctrl_q[pdrt_pkg::CTRL_ENABLE_BIT];
  assign tq_sel  = ctrl_q[pdrt_pkg::CTRL_TQSEL_BIT];
  assign det_max = ctrl_q[pdrt_pkg::CTRL_REVC0_BIT] ? pdrt_pkg::DET_MAX_C0
                                                    : pdrt_pkg::DET_MAX_C1;

  // Out-of-range writes saturate rather than being dropped
  always_comb begin
    det_wr = wdata_i[pdrt_pkg::DET_W-1:0];
    if (wdata_i[31:pdrt_pkg::DET_W] != '0 || det_wr > det_max) begin
      det_wr = det_max; // RULE_07
    end else if (det_wr < pdrt_pkg::DET_MIN_MS) begin
      det_wr = pdrt_pkg::DET_MIN_MS; // RULE_07
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ctrl_q <= pdrt_pkg::CTRL_RESET;
    end else if (wr_i && addr_i == pdrt_pkg::OFF_CTRL) begin
      ctrl_q <= wdata_i[2:0];
    end
  end

  // Narrowing the range re-clamps the stored time
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      det_q <= pdrt_pkg::DET_RESET_MS; // RULE_08
    end else if (wr_i && addr_i == pdrt_pkg::OFF_DETECT) begin
      det_q <= det_wr; // RULE_02
    end else if (det_q > det_max) begin
      det_q <= det_max; // RULE_07
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      mask_q <= pdrt_pkg::IRQ_MASK_RST;
    end else if (wr_i && addr_i == pdrt_pkg::OFF_IRQ_MASK) begin
      mask_q <= wdata_i[pdrt_pkg::IRQ_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // Millisecond timer
  // ------------------------------------------------------------
  pdrt_pkg::pdrt_state_t      state_q;
  pdrt_pkg::pdrt_state_t      state_d;
  logic [pdrt_pkg::PRESC_W-1:0] presc_q;
  logic [pdrt_pkg::DET_W-1:0]   ms_q;
  logic                       ms_tick;
  logic                       enter_ride;

  assign ms_tick = (presc_q == pdrt_pkg::PRESC_W'(MS_CYCLES - 1));

  // Prescaler restarts on entry so the first ms is a whole one
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      presc_q <= '0;
      ms_q    <= '0;
    end else if (state_q != pdrt_pkg::PDRT_RIDE) begin
      presc_q <= '0; // RULE_16
      ms_q    <= '0; // RULE_16
    end else if (ms_tick) begin
      presc_q <= '0;
      ms_q    <= ms_q + 1'b1; // RULE_16
    end else begin
      presc_q <= presc_q + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Ride-through state machine
  // ------------------------------------------------------------
  logic cp_alarm_q;
  logic bus_alarm_q;
  logic cp_fire;
  logic bus_fire;
  logic ride_ok;

  assign enter_ride = (state_q == pdrt_pkg::PDRT_NORMAL) && mon_q.ctrl_power_lost &&
                      ena && drive_i.servo_running;

  always_comb begin
    state_d  = state_q;
    cp_fire  = 1'b0;
    bus_fire = 1'b0;
    ride_ok  = 1'b0;
    unique case (state_q)
      pdrt_pkg::PDRT_NORMAL: begin
        if (mon_q.bus_below_normal) begin
          bus_fire = 1'b1; // RULE_06
          state_d  = pdrt_pkg::PDRT_ALARM;
        end else if (enter_ride) begin
          state_d = pdrt_pkg::PDRT_RIDE; // RULE_10
        end else if (mon_q.ctrl_power_lost) begin
          cp_fire = 1'b1;
          state_d = pdrt_pkg::PDRT_ALARM;
        end
      end
      pdrt_pkg::PDRT_RIDE: begin
        if (mon_q.bus_below_alt) begin
          bus_fire = 1'b1; // RULE_12
          state_d  = pdrt_pkg::PDRT_ALARM;
        end else if (ms_q >= det_q) begin
          cp_fire = 1'b1; // RULE_09
          state_d = pdrt_pkg::PDRT_ALARM;
        end else if (!mon_q.ctrl_power_lost) begin
          ride_ok = 1'b1; // RULE_13
          state_d = pdrt_pkg::PDRT_NORMAL; // RULE_17
        end
      end
      pdrt_pkg::PDRT_ALARM: begin
        state_d = pdrt_pkg::PDRT_ALARM; // RULE_17
      end
      default: begin
        state_d = pdrt_pkg::PDRT_ALARM;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_q <= pdrt_pkg::PDRT_NORMAL;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cp_alarm_q  <= 1'b0;
      bus_alarm_q <= 1'b0;
    end else begin
      cp_alarm_q  <= cp_alarm_q | cp_fire;   // RULE_17
      bus_alarm_q <= bus_alarm_q | bus_fire; // RULE_17
    end
  end

  // ------------------------------------------------------------
  // Drive outputs
  // ------------------------------------------------------------
  // Outputs follow the next state so alarm and brake change together
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ride_through_active_out_o <= 1'b0;
      malfunction_out_o         <= 1'b0;
      warning_out_o             <= 1'b0;
      brake_interlock_out_o     <= 1'b0;
      uv_level_alt_o            <= 1'b0;
    end else begin
      ride_through_active_out_o <= (state_d == pdrt_pkg::PDRT_RIDE); // RULE_10
      warning_out_o             <= (state_d == pdrt_pkg::PDRT_RIDE);
      uv_level_alt_o            <= (state_d == pdrt_pkg::PDRT_RIDE); // RULE_01 RULE_03
      malfunction_out_o         <= (state_d == pdrt_pkg::PDRT_ALARM);
      brake_interlock_out_o     <= (state_d != pdrt_pkg::PDRT_ALARM); // RULE_04 RULE_11
    end
  end

  // Limit only while the drive reports acceleration
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      torque_limit_o <= 1'b0;
    end else begin
      torque_limit_o <= (state_d == pdrt_pkg::PDRT_RIDE) && tq_sel &&
                        drive_i.servo_running && drive_i.accelerating; // RULE_05
    end
  end

  // ------------------------------------------------------------
  // Interrupts and read port
  // ------------------------------------------------------------
  logic [pdrt_pkg::IRQ_W-1:0] stat_q;
  logic [pdrt_pkg::IRQ_W-1:0] stat_ev;
  logic [pdrt_pkg::IRQ_W-1:0] stat_d;
  logic                     stat_rd;

  assign stat_rd = rd_i && addr_i == pdrt_pkg::OFF_IRQ_STAT;

  always_comb begin
    stat_ev = '0;
    stat_ev[pdrt_pkg::IRQ_CP_ALARM]  = cp_fire;
    stat_ev[pdrt_pkg::IRQ_BUS_ALARM] = bus_fire;
    stat_ev[pdrt_pkg::IRQ_RIDE_ON]   = enter_ride;
    stat_ev[pdrt_pkg::IRQ_RIDE_OK]   = ride_ok;
    // Event in the clearing cycle survives the read
    stat_d = (stat_rd ? '0 : stat_q) | stat_ev;
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      stat_q <= '0;
      irq_o  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_o  <= |(stat_d & mask_q);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      unique case (addr_i)
        pdrt_pkg::OFF_CTRL:     rdata_o <= {29'h0, ctrl_q};
        pdrt_pkg::OFF_DETECT:   rdata_o <= {22'h0, det_q};
        pdrt_pkg::OFF_STATUS:   rdata_o <= {14'h0, ms_q, 4'h0, cp_alarm_q,
                                            bus_alarm_q, state_q};
        pdrt_pkg::OFF_IRQ_STAT: rdata_o <= {28'h0, stat_q};
        pdrt_pkg::OFF_IRQ_MASK: rdata_o <= {28'h0, mask_q};
        default:                rdata_o <= 32'h0;
      endcase
    end else begin
      rdata_o <= 32'h0;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_brake_in_ride: assert property ( // RULE_04
    @(posedge core_clk_i) disable iff (reset_i)
    ride_through_active_out_o |-> brake_interlock_out_o)
    else $error("brake interlock dropped during ride-through");

  a_brake_on_alarm: assert property ( // RULE_11
    @(posedge core_clk_i) disable iff (reset_i)
    $rose(malfunction_out_o) |-> $fell(brake_interlock_out_o))
    else $error("brake interlock not dropped with alarm");

  a_level_follows_ride: assert property ( // RULE_03
    @(posedge core_clk_i) disable iff (reset_i)
    uv_level_alt_o == (state_q == pdrt_pkg::PDRT_RIDE))
    else $error("undervoltage level not switched with ride-through");

  a_ride_no_alarm: assert property ( // RULE_01
    @(posedge core_clk_i) disable iff (reset_i)
    ride_through_active_out_o |-> !malfunction_out_o)
    else $error("alarm shown during ride-through");

  a_ride_starts: assert property ( // RULE_10
    @(posedge core_clk_i) disable iff (reset_i)
    (enter_ride && !mon_q.bus_below_normal) |=> ride_through_active_out_o)
    else $error("ride-through output missing after loss");

  a_cp_alarm_time: assert property ( // RULE_09
    @(posedge core_clk_i) disable iff (reset_i)
    (state_q == pdrt_pkg::PDRT_RIDE && !mon_q.bus_below_alt && ms_q >= det_q)
    |=> cp_alarm_q && malfunction_out_o)
    else $error("control-power alarm late");

  a_cp_alarm_early: assert property ( // RULE_16
    @(posedge core_clk_i) disable iff (reset_i)
    ($rose(cp_alarm_q) && $past(state_q) == pdrt_pkg::PDRT_RIDE)
    |-> $past(ms_q) >= $past(det_q))
    else $error("control-power alarm before detection time");

  a_bus_alarm_ride: assert property ( // RULE_12
    @(posedge core_clk_i) disable iff (reset_i)
    (state_q == pdrt_pkg::PDRT_RIDE && mon_q.bus_below_alt)
    |=> bus_alarm_q && !brake_interlock_out_o)
    else $error("bus drop during ride-through not alarmed");

  a_bus_alarm_norm: assert property ( // RULE_06
    @(posedge core_clk_i) disable iff (reset_i)
    (state_q == pdrt_pkg::PDRT_NORMAL && mon_q.bus_below_normal) |=> bus_alarm_q)
    else $error("bus collapse not alarmed");

  a_clean_return: assert property ( // RULE_13
    @(posedge core_clk_i) disable iff (reset_i)
    (state_q == pdrt_pkg::PDRT_RIDE && !mon_q.ctrl_power_lost &&
     !mon_q.bus_below_alt && ms_q < det_q)
    |=> !ride_through_active_out_o && !malfunction_out_o ##1 ms_q == '0)
    else $error("clean power return mishandled");

  a_alarm_latched: assert property ( // RULE_17
    @(posedge core_clk_i) disable iff (reset_i)
    malfunction_out_o |=> malfunction_out_o [*3])
    else $error("alarm released without reset");

  a_det_range: assert property ( // RULE_07
    @(posedge core_clk_i) disable iff (reset_i)
    $past(wr_i) && $past(addr_i) == pdrt_pkg::OFF_DETECT
    |-> det_q >= pdrt_pkg::DET_MIN_MS && det_q <= pdrt_pkg::DET_MAX_C1)
    else $error("detection time out of range");

  a_torque_gate: assert property ( // RULE_05
    @(posedge core_clk_i) disable iff (reset_i)
    torque_limit_o |-> ride_through_active_out_o && $past(tq_sel))
    else $error("torque limited outside ride-through");

endmodule

/* File: dv/pdrt_supply_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Control and main circuit supply monitors
// ------------------------------------------------------------
// Thresholds are arbitrary model levels, not real bus voltages
module pdrt_supply_model #(
  parameter int unsigned NORM_LVL = 200,
  parameter int unsigned ALT_LVL  = 150
) (
  input  wire logic          cp_lost_i,
  input  wire logic [15:0]   bus_lvl_i,
  output pdrt_pkg::pdrt_mon_t mon_o
);
  // Comparator pins are asynchronous, so they follow the level at once
  assign mon_o.ctrl_power_lost  = cp_lost_i;
  assign mon_o.bus_below_normal = (bus_lvl_i < 16'(NORM_LVL));
  assign mon_o.bus_below_alt    = (bus_lvl_i < 16'(ALT_LVL));
endmodule

/* File: dv/test_power_dip_ride_through.sv */
`timescale 1ns/1ps
module test_power_dip_ride_through;
  // ------------------------------------------------------------
  // Bench signals
  // ------------------------------------------------------------
  localparam int unsigned MSC    = 4;
  localparam int unsigned LIMIT  = 20000;
  localparam logic [15:0] BUS_OK  = 16'h00FA;
  localparam logic [15:0] BUS_MID = 16'h00B4;
  localparam logic [15:0] BUS_LOW = 16'h0064;
  logic clk, rst, wr, rd, cp_lost, irq, ride, malf, warn, brake, uv_alt, tq;
  logic [15:0] bus_lvl;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, v;
  pdrt_pkg::pdrt_mon_t   mon;
  pdrt_pkg::pdrt_drive_t drive;
  int mismatches, check_count, cycles, n, d;
  int corner[6] = '{0, 29, 30, 200, 201, 1024};

  pdrt_supply_model supply (.cp_lost_i(cp_lost), .bus_lvl_i(bus_lvl), .mon_o(mon));
  pdrt_top #(.MS_CYCLES(MSC)) dut (
    .core_clk_i(clk), .reset_i(rst), .mon_i(mon), .drive_i(drive), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq),
    .ride_through_active_out_o(ride), .malfunction_out_o(malf), .warning_out_o(warn),
    .brake_interlock_out_o(brake), .uv_level_alt_o(uv_alt), .torque_limit_o(tq));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      give_verdict;
    end
  end

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task wr_reg(input logic [7:0] a, input logic [31:0] dat);
    @(posedge clk);
    addr <= a;
    wdata <= dat;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task chk_reg(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(what, rdata, exp); // Read data stand one cycle only
  endtask

  task do_reset;
    @(posedge clk);
    rst <= 1'b1;
    cp_lost <= 1'b0;
    bus_lvl <= BUS_OK;
    drive <= 2'b10;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Bounded wait; which 0 waits for ride-through, 1 for the alarm
  task wait_high(input int which, input int lim, output int cyc);
    cyc = 0;
    while (cyc < lim && !(which ? malf === 1'b1 : ride === 1'b1)) begin
      @(posedge clk);
      #1 cyc++;
    end
  endtask

  function automatic logic [31:0] clamp(input int unsigned val, input bit c0);
    if (val < 30) return 32'h1E;
    if (val > (c0 ? 200 : 500)) return c0 ? 32'hC8 : 32'h1F4;
    return 32'(val);
  endfunction

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
    cp_lost = 1'b0; bus_lvl = BUS_OK; drive = 2'b10;
    void'($urandom(34));
    do_reset;
    chk_reg("ctrl reset", pdrt_pkg::OFF_CTRL, 32'h5);
    chk_reg("detect reset", pdrt_pkg::OFF_DETECT, 32'hC8);
    chk_reg("mask reset", pdrt_pkg::OFF_IRQ_MASK, 32'h0);
    chk_reg("unmapped", 8'h20, 32'h0);
    wr_reg(pdrt_pkg::OFF_STATUS, 32'hFFFF_FFFF);
    chk_reg("status ro", pdrt_pkg::OFF_STATUS, 32'h0);
    chk("brake idle", brake, 1'b1);
    $display("test reset done");

    // Both revision ranges, corners then random values
    for (int r = 0; r < 2; r++) begin
      if (r == 1) wr_reg(pdrt_pkg::OFF_CTRL, 32'h1);
      for (int i = 0; i < 10; i++) begin
        d = (i < 6) ? corner[i] : $urandom_range(0, 700);
        wr_reg(pdrt_pkg::OFF_DETECT, 32'(d));
        chk_reg("detect clamp", pdrt_pkg::OFF_DETECT, clamp(d, r == 0));
      end
    end
    $display("test detect range done");

    // Short losses with the bus healthy, torque limit selected
    for (int k = 0; k < 3; k++) begin
      do_reset;
      wr_reg(pdrt_pkg::OFF_CTRL, 32'h7);
      wr_reg(pdrt_pkg::OFF_DETECT, 32'h1E);
      wr_reg(pdrt_pkg::OFF_IRQ_MASK, 32'h8);
      drive <= 2'b11;
      cp_lost <= 1'b1;
      wait_high(0, 10, n);
      chk("ride on", ride, 1'b1);
      chk("warning", warn, 1'b1);
      chk("alt level", uv_alt, 1'b1);
      chk("torque lim", tq, 1'b1);
      drive <= 2'b10;
      repeat ($urandom_range(20, 90)) @(posedge clk);
      #1 chk("torque free", tq, 1'b0);
      chk("no alarm", malf, 1'b0);
      chk("brake held", brake, 1'b1);
      cp_lost <= 1'b0;
      repeat (5) @(posedge clk);
      #1 chk("ride off", ride, 1'b0);
      chk("no alarm end", malf, 1'b0);
      chk("alt level off", uv_alt, 1'b0);
      chk("irq end", irq, 1'b1);
      chk_reg("irq stat", pdrt_pkg::OFF_IRQ_STAT, 32'hC);
      chk_reg("irq cleared", pdrt_pkg::OFF_IRQ_STAT, 32'h0);
      chk("irq low", irq, 1'b0);
    end
    $display("test short loss done");

    // Long loss: alarm after the programmed time, then latched
    do_reset;
    d = $urandom_range(30, 40);
    wr_reg(pdrt_pkg::OFF_DETECT, 32'(d));
    cp_lost <= 1'b1;
    wait_high(0, 10, n);
    wait_high(1, 200, n);
    chk("alarm time", n >= d * MSC - 1 && n <= d * MSC + 2, 1'b1);
    chk("brake drop", brake, 1'b0);
    chk("ride cut", ride, 1'b0);
    chk("irq masked", irq, 1'b0);
    wr_reg(pdrt_pkg::OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk("irq unmasked", irq, 1'b1);
    // Timer count is cleared once the alarm state is entered
    chk_reg("cp status", pdrt_pkg::OFF_STATUS, 32'h0000_000A);
    cp_lost <= 1'b0;
    repeat (10) @(posedge clk);
    #1 chk("latched", malf, 1'b1);
    $display("test long loss done");

    // Bus collapse during a short loss, and in normal running
    for (int k = 0; k < 2; k++) begin
      do_reset;
      if (k == 0) begin
        cp_lost <= 1'b1;
        wait_high(0, 10, n);
        bus_lvl <= BUS_MID;
        repeat (10) @(posedge clk);
        #1 chk("alt level ok", malf, 1'b0);
      end
      bus_lvl <= BUS_LOW;
      wait_high(1, 10, n);
      chk("bus alarm", n < 10, 1'b1);
      chk("bus brake", brake, 1'b0);
      chk_reg("bus status", pdrt_pkg::OFF_STATUS, 32'h6);
    end
    $display("test bus drop done");
    give_verdict;
  end
endmodule
